// File: hw/i2c_data_encoding_unit.v
// Data encoding and framing stage behind the two-wire serial interface
`timescale 1ns/100ps
`default_nettype none
`include "i2c_enc_defines.vh"
module i2c_data_encoding_unit (
   input  wire        CLK_I,
   input  wire        RST_B_I,
   // AHB-Lite slave
   input  wire        HSEL_I,
   input  wire [31:0] HADDR_I,
   input  wire [1:0]  HTRANS_I,
   input  wire        HWRITE_I,
   input  wire [2:0]  HSIZE_I,
   input  wire [31:0] HWDATA_I,
   input  wire        HREADY_I,
   output wire        HREADYOUT_O,
   output wire        HRESP_O,
   output reg  [31:0] HRDATA_O,
   // Received byte stream from the line engine
   input  wire        RX_VALID_I,
   input  wire [7:0]  RX_BYTE_I,
   // Decoded units
   output reg         OUT_VALID_O,
   output reg  [31:0] OUT_DATA_O,
   output reg  [2:0]  OUT_KIND_O,
   output reg  [2:0]  OUT_LEN_O,
   output wire        LOW_FIRST_O,
   // Transmit side
   input  wire        TX_REQ_I,
   input  wire        TX_EMPTY_I,
   input  wire [7:0]  TX_DATA_I,
   output reg  [7:0]  TX_BYTE_O,
   // Addressing and rate
   input  wire [6:0]  BUS_ADDR_I,
   output wire        ADDR_HIT_O,
   output wire        MASTER_O,
   output reg  [6:0]  TARGET_ADDR_O,
   output reg         XFER_START_O,
   output reg         BIT_TICK_O,
   output wire        IRQ_O
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg  [4:0]  encode;
   reg  [2:0]  trig;
   reg         master;
   reg         active;
   reg  [7:0]  term;
   reg  [23:0] count_trig;
   reg  [7:0]  fill;
   reg  [6:0]  own_addr;
   reg  [8:0]  speed;
   reg  [2:0]  status;
   reg  [2:0]  mask;
   reg  [23:0] rx_count;
   reg  [7:0]  ph_addr;
   reg         ph_write;
   wire        addr_phase = HSEL_I & HREADY_I & HTRANS_I[1];

   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   // Zero-wait slave: every transfer completes in its first data cycle
   assign HREADYOUT_O = 1'b1;
   assign HRESP_O     = 1'b0;
   assign MASTER_O    = master;
   assign IRQ_O       = |(status & mask);

   wire wr_en = ph_write;
   wire [8:0] wr_speed = HWDATA_I[8:0];

   always @(posedge CLK_I) begin
      if (!RST_B_I) begin
         ph_addr  <= 8'h00;
         ph_write <= 1'b0;
      end else begin
         ph_addr  <= HADDR_I[7:0];
         ph_write <= addr_phase & HWRITE_I;
      end
   end

   // Read data registered in the address phase so it stands in the data phase
   always @(posedge CLK_I) begin
      if (!RST_B_I) begin
         HRDATA_O <= 32'h0000_0000;
      end else if (addr_phase & ~HWRITE_I) begin
         case (HADDR_I[7:0])
            `OFS_CTRL:   HRDATA_O <= {22'h0, active, master, trig, encode};
            `OFS_TERM:   HRDATA_O <= {24'h0, term};
            `OFS_COUNT:  HRDATA_O <= {8'h0, count_trig};
            `OFS_FILL:   HRDATA_O <= {24'h0, fill};
            `OFS_OWNADR: HRDATA_O <= {25'h0, own_addr};
            `OFS_SPEED:  HRDATA_O <= {23'h0, speed};
            `OFS_XFER:   HRDATA_O <= {25'h0, TARGET_ADDR_O};
            `OFS_STATUS: HRDATA_O <= {29'h0, status};
            `OFS_MASK:   HRDATA_O <= {29'h0, mask};
            `OFS_OUT:    HRDATA_O <= OUT_DATA_O;
            `OFS_RXCNT:  HRDATA_O <= {8'h0, rx_count};
            default:     HRDATA_O <= 32'h0000_0000;
         endcase
      end
   end

   always @(posedge CLK_I) begin
      if (!RST_B_I) begin
         encode     <= `ENC_TEXT_ESC;
         trig       <= `TRIG_ALL;
         master     <= 1'b0;
         active     <= 1'b0;
         term       <= 8'h00;
         count_trig <= 24'h00_0000;
         fill       <= `RST_FILL;
         own_addr   <= 7'h00;
         speed      <= `RST_SPEED;
         mask       <= 3'h0;
      end else if (wr_en) begin
         case (ph_addr)
            `OFS_CTRL: begin
               encode <= HWDATA_I[4:0];
               trig   <= HWDATA_I[7:5];
               master <= HWDATA_I[8];
               active <= HWDATA_I[9];
            end
            `OFS_TERM:   term       <= HWDATA_I[7:0];
            `OFS_COUNT:  count_trig <= HWDATA_I[23:0];
            `OFS_FILL:   fill       <= HWDATA_I[7:0];
            `OFS_OWNADR: own_addr   <= HWDATA_I[6:0];
            `OFS_SPEED: begin
               if (wr_speed < `SPEED_MIN) begin
                  speed <= `SPEED_MIN;
               end else if (wr_speed > `SPEED_MAX) begin
                  speed <= `SPEED_MAX;
               end else begin
                  speed <= wr_speed;
               end
            end
            `OFS_MASK:   mask       <= HWDATA_I[2:0];
            default: ;
         endcase
      end
   end

   always @(posedge CLK_I) begin
      if (!RST_B_I) begin
         TARGET_ADDR_O <= 7'h00;
         XFER_START_O  <= 1'b0;
      end else begin
         XFER_START_O <= wr_en & (ph_addr == `OFS_XFER) & master & active;
         if (wr_en && ph_addr == `OFS_XFER) begin
            TARGET_ADDR_O <= HWDATA_I[6:0];
         end
      end
   end

   assign ADDR_HIT_O = active & ~master & (BUS_ADDR_I == own_addr);

   // ----------------------------------------
   // Rate generator
   // ----------------------------------------
   // Phase accumulator gives the exact average kbit rate without a divider
   reg  [15:0] phase;
   wire [15:0] phase_sum = phase + {7'h00, speed};
   always @(posedge CLK_I) begin
      if (!RST_B_I) begin
         phase      <= 16'h0000;
         BIT_TICK_O <= 1'b0;
      end else if (master & active) begin
         if (phase_sum >= `CLK_KHZ) begin
            phase      <= phase_sum - `CLK_KHZ;
            BIT_TICK_O <= 1'b1;
         end else begin
            phase      <= phase_sum;
            BIT_TICK_O <= 1'b0;
         end
      end else begin
         phase      <= 16'h0000;
         BIT_TICK_O <= 1'b0;
      end
   end

   // ----------------------------------------
   // Transmit fill
   // ----------------------------------------
   wire fill_used = TX_REQ_I & TX_EMPTY_I & active;
   always @(posedge CLK_I) begin
      if (!RST_B_I) begin
         TX_BYTE_O <= `RST_FILL;
      end else if (TX_REQ_I) begin
         TX_BYTE_O <= TX_EMPTY_I ? fill : TX_DATA_I;
      end
   end

   // ----------------------------------------
   // Mode decode
   // ----------------------------------------
   wire is_hex = (encode == `ENC_WIDE_HEX) || (encode >= `ENC_HEX8 && encode <= `ENC_HEX32_LOW);
   wire is_cursor = (encode == `ENC_TEXT_CURSOR) || (encode == `ENC_WIDE_CURSOR) ||
                    (encode == `ENC_MB_CURSOR);
   wire is_group = (encode >= `ENC_D16_HIGH && encode <= `ENC_D32_LOW) || is_hex;
   wire low_first = (encode == `ENC_D8_LOW) || (encode == `ENC_D16_LOW) || (encode == `ENC_D32_LOW) ||
                    (encode == `ENC_HEX16_LOW) || (encode == `ENC_HEX32_LOW);
   assign LOW_FIRST_O = low_first;
   reg [2:0] grp;
   always @* begin
      case (encode)
         `ENC_D16_HIGH, `ENC_D16_LOW, `ENC_WIDE_HEX,
         `ENC_HEX16_HIGH, `ENC_HEX16_LOW: grp = 3'd2;
         `ENC_D32_HIGH, `ENC_D32_LOW,
         `ENC_HEX32_HIGH, `ENC_HEX32_LOW: grp = 3'd4;
         default: grp = 3'd1;
      endcase
   end

   // ----------------------------------------
   // Byte path
   // ----------------------------------------
   wire [3:0] nib;
   wire       nib_ok;
   hex_char_decode u_hex (
      .ch_i  (RX_BYTE_I),
      .nib_o (nib),
      .ok_o  (nib_ok)
   );

   function [7:0] hex_ascii;
      input [3:0] n;
      begin
         hex_ascii = (n < 4'hA) ? {4'h3, n} : (8'h37 + {4'h0, n});
      end
   endfunction

   reg  [31:0] acc;
   reg  [2:0]  bcnt;
   reg  [3:0]  nib_hi;
   reg         nib_have;
   reg         prev_cr;
   wire        rx_take = RX_VALID_I & active;
   wire        enc_wr = wr_en & (ph_addr == `OFS_CTRL);
   // Hex modes feed the assembler one decoded byte per two characters
   wire        byte_in = is_hex ? (rx_take & nib_ok & nib_have) : rx_take;
   wire [7:0]  asm_byte = is_hex ? {nib_hi, nib} : RX_BYTE_I;
   wire [31:0] acc_n = low_first ? {asm_byte, acc[31:8]} : {acc[23:0], asm_byte};
   wire [2:0]  bcnt_n = bcnt + 3'd1;
   wire        grp_done = byte_in & (bcnt_n == grp);
   wire [5:0]  shift_lo = 6'd32 - {grp, 3'b000};
   wire [31:0] grp_mask = (grp == 3'd4) ? 32'hFFFF_FFFF : (grp == 3'd2) ? 32'h0000_FFFF : 32'h0000_00FF;
   wire [31:0] grp_word = low_first ? (acc_n >> shift_lo) : (acc_n & grp_mask);

   // Encoding change flushes any part-built group
   always @(posedge CLK_I) begin
      if (!RST_B_I || enc_wr) begin
         acc      <= 32'h0000_0000;
         bcnt     <= 3'd0;
         nib_hi   <= 4'h0;
         nib_have <= 1'b0;
      end else if (is_group) begin
         if (is_hex && rx_take && nib_ok) begin
            nib_hi   <= nib;
            nib_have <= ~nib_have;
         end
         if (byte_in) begin
            acc  <= grp_done ? 32'h0000_0000 : acc_n;
            bcnt <= grp_done ? 3'd0 : bcnt_n;
         end
      end
   end

   always @(posedge CLK_I) begin
      if (!RST_B_I) begin
         OUT_VALID_O <= 1'b0;
         OUT_DATA_O  <= 32'h0000_0000;
         OUT_KIND_O  <= `KIND_CHAR;
         OUT_LEN_O   <= 3'd1;
      end else if (is_group) begin
         OUT_VALID_O <= grp_done;
         if (grp_done) begin
            OUT_DATA_O <= grp_word;
            OUT_KIND_O <= `KIND_WORD;
            OUT_LEN_O  <= grp;
         end
      end else begin
         OUT_VALID_O <= rx_take;
         if (rx_take) begin
            OUT_LEN_O  <= 3'd1;
            OUT_DATA_O <= {24'h00_0000, RX_BYTE_I};
            if (encode == `ENC_TEXT_ESC) begin
               if (RX_BYTE_I < 8'h20 || RX_BYTE_I >= 8'h80) begin
                  OUT_KIND_O <= `KIND_ESC;
                  OUT_LEN_O  <= 3'd3;
                  OUT_DATA_O <= {8'h00, `CHR_BSL, hex_ascii(RX_BYTE_I[7:4]), hex_ascii(RX_BYTE_I[3:0])};
               end else begin
                  OUT_KIND_O <= `KIND_CHAR;
               end
            end else if (is_cursor) begin
               OUT_KIND_O <= (RX_BYTE_I <= 8'h07) ? `KIND_CMD : `KIND_CHAR;
            end else begin
               OUT_KIND_O <= `KIND_RAW;
            end
         end
      end
   end

   // ----------------------------------------
   // Receive trigger
   // ----------------------------------------
   reg term_hit;
   always @* begin
      case (trig)
         `TRIG_CR:   term_hit = (RX_BYTE_I == `CHR_CR);
         `TRIG_LF:   term_hit = (RX_BYTE_I == `CHR_LF);
         `TRIG_NUL:  term_hit = (RX_BYTE_I == 8'h00);
         `TRIG_CRLF: term_hit = prev_cr & (RX_BYTE_I == `CHR_LF);
         `TRIG_BYTE: term_hit = (RX_BYTE_I == term);
         default:    term_hit = 1'b0;
      endcase
   end

   wire count_mode = (count_trig != 24'h00_0000);
   wire [23:0] rx_count_n = rx_count + 24'h00_0001;
   wire count_hit = rx_take & count_mode & (rx_count_n >= count_trig);
   reg  rx_trig;
   always @* begin
      if (count_mode) begin
         rx_trig = count_hit;
      end else if (trig == `TRIG_ALL) begin
         rx_trig = OUT_VALID_O;
      end else begin
         rx_trig = rx_take & term_hit;
      end
   end

   always @(posedge CLK_I) begin
      if (!RST_B_I) begin
         rx_count <= 24'h00_0000;
         prev_cr  <= 1'b0;
      end else begin
         if (wr_en && ph_addr == `OFS_COUNT) begin
            rx_count <= 24'h00_0000;
         end else if (rx_take) begin
            rx_count <= count_hit ? 24'h00_0000 : rx_count_n;
         end
         if (rx_take) begin
            prev_cr <= (RX_BYTE_I == `CHR_CR);
         end
      end
   end

   // ----------------------------------------
   // Interrupt status
   // ----------------------------------------
   wire [2:0] ev;
   assign ev[`ST_RXTRIG] = rx_trig;
   assign ev[`ST_WORD]   = OUT_VALID_O & (OUT_KIND_O == `KIND_WORD);
   assign ev[`ST_FILL]   = fill_used;
   wire [2:0] clr = (wr_en && ph_addr == `OFS_STATUS) ? HWDATA_I[2:0] : 3'h0;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_st
         // New event wins over a same-cycle clear
         always @(posedge CLK_I) begin
            if (!RST_B_I) begin
               status[gi] <= 1'b0;
            end else begin
               status[gi] <= ev[gi] | (status[gi] & ~clr[gi]);
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// File: inc/i2c_enc_defines.vh
// Offsets, fields, reset values and codes of the two-wire data encoding unit
`ifndef I2C_ENC_DEFINES_VH
`define I2C_ENC_DEFINES_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL    8'h00
`define OFS_TERM    8'h04
`define OFS_COUNT   8'h08
`define OFS_FILL    8'h0C
`define OFS_OWNADR  8'h10
`define OFS_SPEED   8'h14
`define OFS_XFER    8'h18
`define OFS_STATUS  8'h1C
`define OFS_MASK    8'h20
`define OFS_OUT     8'h24
`define OFS_RXCNT   8'h28
// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define RST_FILL    8'hFF
`define RST_SPEED   9'h064
`define SPEED_MIN   9'h014
`define SPEED_MAX   9'h190
`define CLK_KHZ     16'h61A8
// ----------------------------------------
// Encoding codes, CTRL[4:0]
// ----------------------------------------
`define ENC_TEXT_ESC      5'h00
`define ENC_TEXT_CURSOR   5'h01
`define ENC_RAW_PASS      5'h02
`define ENC_WIDE_HEX      5'h03
`define ENC_WIDE_CURSOR   5'h04
`define ENC_WIDE_RAW      5'h05
`define ENC_MB_CURSOR     5'h06
`define ENC_MB_RAW        5'h07
`define ENC_MB_RAW2       5'h08
`define ENC_D8_HIGH       5'h09
`define ENC_D8_LOW        5'h0A
`define ENC_D16_HIGH      5'h0B
`define ENC_D16_LOW       5'h0C
`define ENC_D32_HIGH      5'h0D
`define ENC_D32_LOW       5'h0E
`define ENC_HEX8          5'h0F
`define ENC_HEX16_HIGH    5'h10
`define ENC_HEX16_LOW     5'h11
`define ENC_HEX32_HIGH    5'h12
`define ENC_HEX32_LOW     5'h13
// ----------------------------------------
// Trigger codes, CTRL[7:5]; CTRL[8] master; CTRL[9] active
// ----------------------------------------
`define TRIG_ALL    3'h0
`define TRIG_CR     3'h1
`define TRIG_LF     3'h2
`define TRIG_NUL    3'h3
`define TRIG_CRLF   3'h4
`define TRIG_BYTE   3'h5
`define CHR_CR      8'h0D
`define CHR_LF      8'h0A
`define CHR_BSL     8'h5C
// ----------------------------------------
// Output kinds and status bits
// ----------------------------------------
`define KIND_CHAR   3'h0
`define KIND_CMD    3'h1
`define KIND_ESC    3'h2
`define KIND_RAW    3'h3
`define KIND_WORD   3'h4
`define ST_RXTRIG   0
`define ST_WORD     1
`define ST_FILL     2
`endif

// File: hw/hex_char_decode.v
// ASCII hex character to nibble decoder
`timescale 1ns/100ps
`default_nettype none
module hex_char_decode (
   input  wire [7:0] ch_i,
   output reg  [3:0] nib_o,
   output reg        ok_o
);
   always @* begin
      nib_o = 4'h0;
      ok_o  = 1'b1;
      if (ch_i >= 8'h30 && ch_i <= 8'h39) begin
         nib_o = ch_i[3:0];
      end else if ((ch_i >= 8'h41 && ch_i <= 8'h46) || (ch_i >= 8'h61 && ch_i <= 8'h66)) begin
         nib_o = ch_i[3:0] + 4'h9;
      end else begin
         ok_o = 1'b0;
      end
   end
endmodule
`default_nettype wire

// File: verif/i2c_data_encoding_unit_properties.sv
// Port assertions for the data encoding unit
`timescale 1ns/100ps
`default_nettype none
`include "i2c_enc_defines.vh"
module enc_unit_checker (
   input wire logic        CLK_I,
   input wire logic        RST_B_I,
   input wire logic        HREADYOUT_O,
   input wire logic        HRESP_O,
   input wire logic        RX_VALID_I,
   input wire logic        OUT_VALID_O,
   input wire logic [31:0] OUT_DATA_O,
   input wire logic [2:0]  OUT_KIND_O,
   input wire logic [2:0]  OUT_LEN_O,
   input wire logic        TX_REQ_I,
   input wire logic        TX_EMPTY_I,
   input wire logic [7:0]  TX_DATA_I,
   input wire logic [7:0]  TX_BYTE_O,
   input wire logic        ADDR_HIT_O,
   input wire logic        MASTER_O,
   input wire logic        XFER_START_O,
   input wire logic        BIT_TICK_O,
   input wire logic        IRQ_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RST_B_I);
   // ----------------------------------------
   // Sequences
   // ----------------------------------------
   sequence buf_pull;
      TX_REQ_I && !TX_EMPTY_I;
   endsequence
   sequence esc_unit;
      OUT_VALID_O && OUT_KIND_O == `KIND_ESC;
   endsequence
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   a_bus_okay: assert property (HREADYOUT_O && !HRESP_O)
      else $error("bus stalled or errored");
   a_reset_outputs: assert property (!$past(RST_B_I) |-> TX_BYTE_O == 8'hFF && !IRQ_O)
      else $error("outputs wrong after reset");
   a_unit_cause: assert property (OUT_VALID_O |-> $past(RX_VALID_I))
      else $error("unit without a byte taken");
   a_escape_form: assert property (esc_unit |-> OUT_DATA_O[31:16] == 16'h005C && OUT_LEN_O == 3'h3)
      else $error("escape unit malformed");
   a_cmd_range: assert property (OUT_VALID_O && OUT_KIND_O == `KIND_CMD |-> OUT_DATA_O <= 32'h7)
      else $error("cursor command out of range");
   a_tx_data: assert property (buf_pull |=> TX_BYTE_O == $past(TX_DATA_I))
      else $error("buffered byte not returned");
   a_tx_hold: assert property (!$past(TX_REQ_I) |-> $stable(TX_BYTE_O))
      else $error("returned byte changed unasked");
   a_slave_addr: assert property (MASTER_O |-> !ADDR_HIT_O)
      else $error("own address matched as master");
   a_xfer_master: assert property (XFER_START_O |-> MASTER_O)
      else $error("transfer started as slave");
   a_tick_slave: assert property (!MASTER_O && !$past(MASTER_O) |-> !BIT_TICK_O)
      else $error("bit tick as slave");
   a_tick_gap: assert property (BIT_TICK_O |=> !BIT_TICK_O [*8])
      else $error("bit ticks too close");
endmodule
bind i2c_data_encoding_unit enc_unit_checker u_props (
   .CLK_I(CLK_I), .RST_B_I(RST_B_I), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
   .RX_VALID_I(RX_VALID_I), .OUT_VALID_O(OUT_VALID_O), .OUT_DATA_O(OUT_DATA_O), .OUT_KIND_O(OUT_KIND_O),
   .OUT_LEN_O(OUT_LEN_O), .TX_REQ_I(TX_REQ_I), .TX_EMPTY_I(TX_EMPTY_I), .TX_DATA_I(TX_DATA_I),
   .TX_BYTE_O(TX_BYTE_O), .ADDR_HIT_O(ADDR_HIT_O), .MASTER_O(MASTER_O), .XFER_START_O(XFER_START_O),
   .BIT_TICK_O(BIT_TICK_O), .IRQ_O(IRQ_O)
);
`default_nettype wire

// File: verif/two_wire_far_end.sv
// Far-end model: line engine bytes, transmit pulls, bus address
`timescale 1ns/100ps
`default_nettype none
module two_wire_far_end (
   input  wire logic       clk_i,
   input  wire logic [7:0] tx_byte_i,
   output logic            rx_valid_o,
   output logic [7:0]      rx_byte_o,
   output logic            tx_req_o,
   output logic            tx_empty_o,
   output logic [7:0]      tx_data_o,
   output logic [6:0]      bus_addr_o
);
   initial begin
      rx_valid_o = 1'b0;
      rx_byte_o = 8'hA5;
      tx_req_o = 1'b0;
      tx_empty_o = 1'b1;
      tx_data_o = 8'h5A;
      bus_addr_o = 7'h00;
   end
   // ----------------------------------------
   // Requests
   // ----------------------------------------
   // Released data flips so a stale byte cannot pass for a new one
   task automatic send(input logic [7:0] b);
      rx_valid_o <= 1'b1;
      rx_byte_o <= b;
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_byte_o <= ~b;
      @(posedge clk_i);
   endtask
   task automatic pull(input logic e, input logic [7:0] d, output logic [7:0] got);
      tx_req_o <= 1'b1;
      tx_empty_o <= e;
      tx_data_o <= d;
      @(posedge clk_i);
      tx_req_o <= 1'b0;
      tx_data_o <= ~d;
      @(posedge clk_i);
      got = tx_byte_i;
   endtask
   task automatic addr(input logic [6:0] a);
      bus_addr_o <= a;
   endtask
endmodule
`default_nettype wire

// File: verif/i2c_data_encoding_unit_tb.sv
// Self-checking testbench for the data encoding unit
`timescale 1ns/100ps
`default_nettype none
`include "i2c_enc_defines.vh"
module i2c_data_encoding_unit_tb;
   logic        clk;
   logic        rst_b;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] rd;
   logic [7:0]  got;
   logic [37:0] units[$];
   int          mismatches;
   int          comparisons;
   int          ticks;
   int          t0;
   int          xfers;
   wire         hready, hresp, rx_valid, tx_req, tx_empty, out_valid, low_first, addr_hit, master, xfer_start;
   wire         bit_tick, irq;
   wire  [31:0] hrdata, out_data;
   wire  [7:0]  rx_byte, tx_data, tx_byte;
   wire  [6:0]  bus_addr, target;
   wire  [2:0]  out_kind, out_len;
   logic [4:0]  curs[3] = '{`ENC_TEXT_CURSOR, `ENC_WIDE_CURSOR, `ENC_MB_CURSOR};
   logic [4:0]  raws[6] = '{`ENC_RAW_PASS, `ENC_WIDE_RAW, `ENC_MB_RAW, `ENC_MB_RAW2, `ENC_D8_HIGH, `ENC_D8_LOW};
   logic [4:0]  hexs[5] = '{`ENC_WIDE_HEX, `ENC_HEX16_HIGH, `ENC_HEX16_LOW, `ENC_HEX32_HIGH, `ENC_HEX32_LOW};
   logic [31:0] hexa[5] = '{32'h1234, 32'h1234, 32'h3412, 32'h12345678, 32'h78563412};
   logic [31:0] hexb[5] = '{32'h5678, 32'h5678, 32'h7856, 32'h0, 32'h0};
   logic [2:0]  trigs[5] = '{`TRIG_CR, `TRIG_LF, `TRIG_NUL, `TRIG_BYTE, `TRIG_CRLF};
   logic [7:0]  terms[5] = '{8'h0D, 8'h0A, 8'h00, 8'h1A, 8'h0A};
   logic [7:0]  pres[5] = '{8'h41, 8'h41, 8'h41, 8'h41, 8'h0D};
   i2c_data_encoding_unit dut (
      .CLK_I(clk), .RST_B_I(rst_b), .HSEL_I(1'b1), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
      .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready), .HREADYOUT_O(hready), .HRESP_O(hresp),
      .HRDATA_O(hrdata), .RX_VALID_I(rx_valid), .RX_BYTE_I(rx_byte), .OUT_VALID_O(out_valid),
      .OUT_DATA_O(out_data), .OUT_KIND_O(out_kind), .OUT_LEN_O(out_len), .LOW_FIRST_O(low_first),
      .TX_REQ_I(tx_req), .TX_EMPTY_I(tx_empty), .TX_DATA_I(tx_data), .TX_BYTE_O(tx_byte),
      .BUS_ADDR_I(bus_addr), .ADDR_HIT_O(addr_hit), .MASTER_O(master), .TARGET_ADDR_O(target),
      .XFER_START_O(xfer_start), .BIT_TICK_O(bit_tick), .IRQ_O(irq));
   two_wire_far_end far (
      .clk_i(clk), .tx_byte_i(tx_byte), .rx_valid_o(rx_valid), .rx_byte_o(rx_byte), .tx_req_o(tx_req),
      .tx_empty_o(tx_empty), .tx_data_o(tx_data), .bus_addr_o(bus_addr));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask
   task automatic ctrl(input logic m, input logic [2:0] t, input logic [4:0] e);
      wr(`OFS_CTRL, {22'h0, 1'b1, m, t, e});
   endtask
   task automatic feed(input logic [63:0] s, input int n);
      for (int i = n - 1; i >= 0; i--) far.send(s[i*8 +: 8]);
   endtask
   // Kind 7 means the kind is not compared
   task automatic unit(input logic [2:0] k, input logic [2:0] l, input logic [31:0] d);
      logic [37:0] u;
      repeat (2) @(posedge clk);
      u = units.size() ? units.pop_front() : 38'bx;
      if (k !== 3'h7) chk({29'h0, u[37:35]}, {29'h0, k});
      chk({29'h0, u[34:32]}, {29'h0, l});
      chk(u[31:0], d);
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge clk) begin
      if (out_valid === 1'b1) units.push_back({out_kind, out_len, out_data});
      if (xfer_start === 1'b1) xfers++;
      if (bit_tick === 1'b1) ticks++;
   end
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      stop_test;
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rst_b <= 1'b0;
      haddr <= 32'h0;
      hwdata <= 32'h0;
      htrans <= 2'h0;
      hwrite <= 1'b0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rdc(`OFS_FILL, 32'hFF, 32'hFF);
      rdc(`OFS_SPEED, 32'h1FF, 32'h64);
      rdc(8'h3C, 32'hFFFFFFFF, 32'h0);
      chk({24'h0, tx_byte}, 32'hFF);
      wr(`OFS_MASK, 32'h7);
      ctrl(1'b0, `TRIG_ALL, `ENC_TEXT_ESC);
      feed(64'h1F8041, 3);
      unit(`KIND_ESC, 3'h3, 32'h005C3146);
      unit(`KIND_ESC, 3'h3, 32'h005C3830);
      unit(`KIND_CHAR, 3'h1, 32'h41);
      foreach (curs[i]) begin
         ctrl(1'b0, `TRIG_ALL, curs[i]);
         feed(64'h0720, 2);
         unit(`KIND_CMD, 3'h1, 32'h07);
         unit(`KIND_CHAR, 3'h1, 32'h20);
      end
      foreach (raws[i]) begin
         ctrl(1'b0, `TRIG_ALL, raws[i]);
         feed(64'h00FF, 2);
         unit(`KIND_RAW, 3'h1, 32'h00);
         unit(`KIND_RAW, 3'h1, 32'hFF);
         chk({31'h0, low_first}, {31'h0, raws[i] == `ENC_D8_LOW});
      end
      // Word pairing and the interrupt path
      ctrl(1'b0, `TRIG_ALL, `ENC_D16_HIGH);
      wr(`OFS_STATUS, 32'h7);
      feed(64'h11, 1);
      rdc(`OFS_STATUS, 32'h3, 32'h0);
      feed(64'h22, 1);
      rdc(`OFS_STATUS, 32'h3, 32'h3);
      chk({31'h0, irq}, 32'h1);
      wr(`OFS_MASK, 32'h0);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      wr(`OFS_MASK, 32'h7);
      wr(`OFS_STATUS, 32'h3);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      feed(64'h3344, 2);
      unit(`KIND_WORD, 3'h2, 32'h1122);
      unit(`KIND_WORD, 3'h2, 32'h3344);
      ctrl(1'b0, `TRIG_ALL, `ENC_D16_LOW);
      feed(64'h11223344, 4);
      unit(`KIND_WORD, 3'h2, 32'h2211);
      unit(`KIND_WORD, 3'h2, 32'h4433);
      ctrl(1'b0, `TRIG_ALL, `ENC_D32_HIGH);
      feed(64'h11223344, 4);
      unit(`KIND_WORD, 3'h4, 32'h11223344);
      ctrl(1'b0, `TRIG_ALL, `ENC_D32_LOW);
      feed(64'h11223344, 4);
      unit(`KIND_WORD, 3'h4, 32'h44332211);
      ctrl(1'b0, `TRIG_ALL, `ENC_HEX8);
      feed(64'h474138, 3);
      unit(3'h7, 3'h1, 32'hA8);
      foreach (hexs[i]) begin
         ctrl(1'b0, `TRIG_ALL, hexs[i]);
         feed(64'h3132333435363738, 8);
         unit(3'h7, i < 3 ? 3'h2 : 3'h4, hexa[i]);
         if (i < 3) unit(3'h7, 3'h2, hexb[i]);
      end
      // Terminators and byte count
      wr(`OFS_TERM, 32'h1A);
      foreach (trigs[i]) begin
         ctrl(1'b0, trigs[i], `ENC_RAW_PASS);
         wr(`OFS_STATUS, 32'h7);
         feed({56'h0, pres[i]}, 1);
         rdc(`OFS_STATUS, 32'h1, 32'h0);
         feed({56'h0, terms[i]}, 1);
         rdc(`OFS_STATUS, 32'h1, 32'h1);
      end
      wr(`OFS_COUNT, 32'h3);
      wr(`OFS_STATUS, 32'h7);
      feed(64'h4142, 2);
      rdc(`OFS_STATUS, 32'h1, 32'h0);
      feed(64'h43, 1);
      rdc(`OFS_STATUS, 32'h1, 32'h1);
      wr(`OFS_COUNT, 32'h0);
      wr(`OFS_STATUS, 32'h7);
      feed(64'h41, 1);
      rdc(`OFS_STATUS, 32'h1, 32'h0);
      // Transmit fill byte
      far.pull(1'b1, 8'h3C, got);
      chk({24'h0, got}, 32'hFF);
      rdc(`OFS_STATUS, 32'h4, 32'h4);
      wr(`OFS_FILL, 32'h5A);
      far.pull(1'b1, 8'h3C, got);
      chk({24'h0, got}, 32'h5A);
      far.pull(1'b0, 8'h3C, got);
      chk({24'h0, got}, 32'h3C);
      rdc(`OFS_CTRL, 32'h3FF, {22'h0, 1'b1, 1'b0, `TRIG_CRLF, `ENC_RAW_PASS});
      // Addressing, master transfers and rate
      wr(`OFS_OWNADR, 32'h3E);
      far.addr(7'h3E);
      @(posedge clk);
      chk({31'h0, addr_hit}, 32'h1);
      wr(`OFS_XFER, 32'h22);
      ctrl(1'b1, `TRIG_ALL, `ENC_RAW_PASS);
      @(posedge clk);
      chk({31'h0, addr_hit}, 32'h0);
      chk(xfers, 32'h0);
      wr(`OFS_XFER, 32'h55);
      repeat (2) @(posedge clk);
      chk({25'h0, target}, 32'h55);
      chk(xfers, 32'h1);
      wr(`OFS_SPEED, 32'h5);
      rdc(`OFS_SPEED, 32'h1FF, 32'h14);
      wr(`OFS_SPEED, 32'h3E8);
      rdc(`OFS_SPEED, 32'h1FF, 32'h190);
      wr(`OFS_SPEED, 32'h64);
      t0 = ticks;
      repeat (2500) @(posedge clk);
      chk({31'h0, ticks - t0 >= 9 && ticks - t0 <= 11}, 32'h1);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rdc(`OFS_FILL, 32'hFF, 32'hFF);
      stop_test;
   end
endmodule
`default_nettype wire
